/* logic/nv_host_consts.svh */
`ifndef NV_HOST_CONSTS_SVH
`define NV_HOST_CONSTS_SVH

`define NV_CLK_PERIOD_NS       10
`define NV_ADDR_W              18
`define NV_DATA_W              16
`define NV_LANE_W              2
`define NV_SEQ_LEN             6
`define NV_CNT_W               22

`define NV_POWERUP_RESTORE_MS  20
`define NV_STORE_MS            8
`define NV_RECALL_US           200
`define NV_SOFT_SEQ_US         100
`define NV_SAVE_PULSE_MIN_NS   15
`define NV_NO_WRITE_RELEASE_NS 25
`define NV_WRITE_GRACE_NS      25
`define NV_BUSY_HIGH_DRIVE_NS  500
`define NV_ACCESS_NS           40
`define NV_RECOVER_NS          20

`define NV_CYC_UP(ns)   ((((ns)) + `NV_CLK_PERIOD_NS - 1) / `NV_CLK_PERIOD_NS)
`define NV_CYC_DOWN(ns) ((ns) / `NV_CLK_PERIOD_NS)

`define NV_SAVE_PULSE_CYC  `NV_CYC_UP(`NV_SAVE_PULSE_MIN_NS)
`define NV_RELEASE_CYC     `NV_CYC_UP(`NV_NO_WRITE_RELEASE_NS)
`define NV_GRACE_CYC       `NV_CYC_UP(`NV_WRITE_GRACE_NS)
`define NV_BUSY_HIGH_CYC   `NV_CYC_UP(`NV_BUSY_HIGH_DRIVE_NS)
`define NV_ACCESS_CYC      `NV_CYC_UP(`NV_ACCESS_NS)
`define NV_RECOVER_CYC     `NV_CYC_UP(`NV_RECOVER_NS)

`endif

/* logic/nv_host_pkg.sv */
package nv_host_pkg;

    typedef enum logic [1:0] {
        CMD_STORE     = 2'h0,
        CMD_RECALL    = 2'h1,
        CMD_SAVE_EN   = 2'h2,
        CMD_SAVE_DIS  = 2'h3
    } nv_cmd_t;

    // Gray steps along power-up, idle, strobe, recover and the save path.
    typedef enum logic [2:0] {
        ST_POWERUP    = 3'h0,
        ST_IDLE       = 3'h1,
        ST_STROBE     = 3'h3,
        ST_RECOVER    = 3'h2,
        ST_SAVE_PULSE = 3'h6,
        ST_SAVE_WAIT  = 3'h7,
        ST_LOCK       = 3'h5
    } nv_state_t;

endpackage : nv_host_pkg

/* logic/nv_cmd_addr_rom.sv */
`include "nv_host_consts.svh"

module nv_cmd_addr_rom
    import nv_host_pkg::*;
#(
    // Six addresses per command, command 0 in the lowest bits; board supplies it.
    parameter logic [4*`NV_SEQ_LEN*`NV_ADDR_W-1:0] CMD_TABLE = '0
) (
    input  wire logic                  clk_sys,
    input  wire logic                  rst,
    input  wire nv_cmd_t               cmd,
    input  wire logic [2:0]            idx,
    output      logic [`NV_ADDR_W-1:0] addr
);

    function automatic logic [4:0] slot(input nv_cmd_t c, input logic [2:0] i);
        slot = 5'(({3'h0, c} * 5'h6) + {2'h0, i});
    endfunction : slot

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            addr <= '0;
        end else begin
            addr <= CMD_TABLE[slot(cmd, idx) * `NV_ADDR_W +: `NV_ADDR_W];
        end
    end

endmodule : nv_cmd_addr_rom

/* logic/nv_host.sv */
`include "nv_host_consts.svh"

module nv_host
    import nv_host_pkg::*;
#(
    parameter int                              RESTORE_CYC  = `NV_POWERUP_RESTORE_MS * 1000000
                                                              / `NV_CLK_PERIOD_NS,
    parameter int                              STORE_CYC    = `NV_STORE_MS * 1000000
                                                              / `NV_CLK_PERIOD_NS,
    parameter int                              RECALL_CYC   = `NV_RECALL_US * 1000
                                                              / `NV_CLK_PERIOD_NS,
    parameter int                              SOFT_SEQ_CYC = `NV_SOFT_SEQ_US * 1000
                                                              / `NV_CLK_PERIOD_NS,
    parameter logic [4*`NV_SEQ_LEN*`NV_ADDR_W-1:0] CMD_TABLE = '0
) (
    input  wire logic                  clk_sys,
    input  wire logic                  rst,
    input  wire logic                  power_good,
    input  wire logic                  req_valid,
    output      logic                  req_ready,
    input  wire logic                  req_write,
    input  wire logic [`NV_ADDR_W-1:0] req_addr,
    input  wire logic [`NV_DATA_W-1:0] req_wdata,
    input  wire logic [`NV_LANE_W-1:0] req_lane_n,
    output      logic                  rsp_valid,
    output      logic [`NV_DATA_W-1:0] rsp_rdata,
    input  wire logic                  cmd_valid,
    output      logic                  cmd_ready,
    input  wire nv_cmd_t               cmd_code,
    input  wire logic                  save_valid,
    output      logic                  save_ready,
    output      logic                  busy,
    output      logic                  unsaved_writes,
    output      logic [`NV_ADDR_W-1:0] mem_addr,
    output      logic                  mem_ce_n,
    output      logic                  mem_we_n,
    output      logic                  mem_oe_n,
    output      logic                  lower_lane_enable_n,
    output      logic                  upper_lane_enable_n,
    input  wire logic [`NV_DATA_W-1:0] dq_in,
    output      logic [`NV_DATA_W-1:0] dq_out,
    output      logic [`NV_LANE_W-1:0] dq_oe,
    input  wire logic                  save_request_busy_pin_in,
    output      logic                  save_request_busy_pin_out,
    output      logic                  save_request_busy_pin_oe
);

    nv_state_t             state, next_state;
    logic [`NV_CNT_W-1:0]  cnt, next_cnt;
    logic [2:0]            seq_idx, next_seq_idx;
    logic                  seq_active, next_seq_active;
    nv_cmd_t               cmd_q, next_cmd_q;
    logic [`NV_LANE_W-1:0] lane_n, next_lane_n;
    logic [`NV_ADDR_W-1:0] next_mem_addr;
    logic [`NV_DATA_W-1:0] next_dq_out, next_rsp_rdata;
    logic [`NV_LANE_W-1:0] next_dq_oe;
    logic                  next_ce_n, next_we_n, next_oe_n, next_pin_oe;
    logic                  next_rsp_valid, next_dirty;
    logic [`NV_ADDR_W-1:0] rom_addr;

    nv_cmd_addr_rom #(.CMD_TABLE(CMD_TABLE)) u_rom (
        .clk_sys (clk_sys),
        .rst     (rst),
        .cmd     (cmd_q),
        .idx     (seq_idx),
        .addr    (rom_addr)
    );

    function automatic logic [`NV_CNT_W-1:0] cyc(input int n);
        cyc = `NV_CNT_W'(n);
    endfunction : cyc
    function automatic logic [`NV_DATA_W-1:0] lane_mask(input logic [`NV_LANE_W-1:0] ln);
        lane_mask = {{8{~ln[1]}}, {8{~ln[0]}}};
    endfunction : lane_mask
    // The save pin is open drain: the host only ever pulls it low.
    assign save_request_busy_pin_out = 1'b0;
    // Requests only taken idle with supply good.
    assign save_ready = (state == ST_IDLE) && power_good;
    assign cmd_ready  = save_ready && !save_valid;
    assign req_ready  = cmd_ready && !cmd_valid;
    assign busy       = (state != ST_IDLE);
    always_comb begin
        next_state      = state;
        next_cnt        = (cnt != '0) ? cnt - 1'b1 : cnt;
        next_seq_idx    = seq_idx;
        next_seq_active = seq_active;
        next_cmd_q      = cmd_q;
        next_lane_n     = lane_n;
        next_mem_addr   = mem_addr;
        next_dq_out     = dq_out;
        next_dq_oe      = dq_oe;
        next_ce_n       = mem_ce_n;
        next_we_n       = mem_we_n;
        next_oe_n       = mem_oe_n;
        next_pin_oe     = save_request_busy_pin_oe;
        next_rsp_valid  = 1'b0;
        next_rsp_rdata  = rsp_rdata;
        next_dirty      = unsaved_writes;
        case (state)
            ST_POWERUP: begin
                if (!power_good) begin
                    next_cnt = cyc(RESTORE_CYC);
                end else if (cnt == '0) begin
                    next_state = ST_IDLE;
                    next_dirty = 1'b0;
                end
            end
            ST_IDLE: begin
                if (save_valid && save_ready) begin
                    next_state  = ST_SAVE_PULSE;
                    next_pin_oe = 1'b1;
                    next_cnt    = cyc(`NV_SAVE_PULSE_CYC - 1);
                end else if (cmd_valid && cmd_ready) begin
                    next_state      = ST_RECOVER;
                    next_seq_active = 1'b1;
                    next_seq_idx    = 3'h0;
                    next_cmd_q      = cmd_code;
                    next_cnt        = cyc(`NV_RECOVER_CYC - 1);
                end else if (req_valid && req_ready) begin
                    if (req_lane_n == 2'h3) begin
                        next_rsp_valid = 1'b1;
                        next_rsp_rdata = '0;
                    end else begin
                        next_state    = ST_STROBE;
                        next_cnt      = cyc(`NV_ACCESS_CYC - 1);
                        next_lane_n   = req_lane_n;
                        next_mem_addr = req_addr;
                        next_dq_out   = req_wdata;
                        next_ce_n     = 1'b0;
                        next_we_n     = !req_write;
                        next_oe_n     = req_write;
                        next_dq_oe    = req_write ? ~req_lane_n : 2'h0;
                        next_dirty    = unsaved_writes | req_write;
                    end
                end
            end
            ST_STROBE: begin
                if (cnt == '0) begin
                    next_state = ST_RECOVER;
                    next_cnt   = cyc(`NV_RECOVER_CYC - 1);
                    // Select rises to end each read.
                    next_ce_n  = 1'b1;
                    next_we_n  = 1'b1;
                    next_oe_n  = 1'b1;
                    next_dq_oe = 2'h0;
                    if (seq_active) begin
                        next_seq_idx = seq_idx + 3'h1;
                    end else begin
                        next_rsp_valid = 1'b1;
                        next_rsp_rdata = !mem_we_n ? '0 : (dq_in & lane_mask(lane_n));
                    end
                end
            end
            ST_RECOVER: begin
                if (cnt == '0) begin
                    if (!seq_active) begin
                        next_state = ST_IDLE;
                    end else if (seq_idx == 3'(`NV_SEQ_LEN)) begin
                        next_state      = ST_LOCK;
                        next_seq_active = 1'b0;
                        case (cmd_q)
                            CMD_STORE: begin
                                next_cnt   = cyc(SOFT_SEQ_CYC + STORE_CYC);
                                next_dirty = 1'b0;
                            end
                            CMD_RECALL: begin
                                next_cnt   = cyc(SOFT_SEQ_CYC + RECALL_CYC);
                                next_dirty = 1'b0;
                            end
                            default: next_cnt = cyc(SOFT_SEQ_CYC);
                        endcase
                    end else begin
                        // Reads only, both lanes, write high.
                        next_state    = ST_STROBE;
                        next_cnt      = cyc(`NV_ACCESS_CYC - 1);
                        next_lane_n   = 2'h0;
                        next_mem_addr = rom_addr;
                        next_ce_n     = 1'b0;
                        next_oe_n     = 1'b0;
                    end
                end
            end
            ST_SAVE_PULSE: begin
                if (cnt == '0) begin
                    next_state  = ST_SAVE_WAIT;
                    next_pin_oe = 1'b0;
                    // Grace and release window before sampling.
                    next_cnt    = cyc(STORE_CYC + ((`NV_GRACE_CYC > `NV_RELEASE_CYC) ?
                                                   `NV_GRACE_CYC : `NV_RELEASE_CYC));
                end
            end
            ST_SAVE_WAIT: begin
                // Pin low means save still running; high means done or skipped.
                if ((save_request_busy_pin_in && cnt <= cyc(STORE_CYC)) || cnt == '0) begin
                    // Device may drive pin high; keep off it.
                    next_state = ST_LOCK;
                    next_cnt   = cyc(`NV_BUSY_HIGH_CYC);
                    next_dirty = 1'b0;
                end
            end
            ST_LOCK: if (cnt == '0) next_state = ST_IDLE;
            default: begin
                next_state = ST_POWERUP;
                next_cnt   = cyc(RESTORE_CYC);
            end
        endcase
        // Supply loss: the device saves on its own; any access, sequence or save pulse is dropped.
        if (!power_good && state != ST_POWERUP) begin
            next_state      = ST_POWERUP;
            next_cnt        = cyc(RESTORE_CYC);
            next_seq_active = 1'b0;
            next_ce_n       = 1'b1;
            next_we_n       = 1'b1;
            next_oe_n       = 1'b1;
            next_dq_oe      = 2'h0;
            next_pin_oe     = 1'b0;
        end
    end

    assign lower_lane_enable_n = lane_n[0];
    assign upper_lane_enable_n = lane_n[1];

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state                    <= ST_POWERUP;
            cnt                      <= `NV_CNT_W'(RESTORE_CYC);
            seq_idx                  <= 3'h0;
            seq_active               <= 1'b0;
            cmd_q                    <= CMD_STORE;
            lane_n                   <= 2'h3;
            mem_addr                 <= '0;
            dq_out                   <= '0;
            dq_oe                    <= 2'h0;
            mem_ce_n                 <= 1'b1;
            mem_we_n                 <= 1'b1;
            mem_oe_n                 <= 1'b1;
            save_request_busy_pin_oe <= 1'b0;
            rsp_valid                <= 1'b0;
            rsp_rdata                <= '0;
            unsaved_writes           <= 1'b0;
        end else begin
            state                    <= next_state;
            cnt                      <= next_cnt;
            seq_idx                  <= next_seq_idx;
            seq_active               <= next_seq_active;
            cmd_q                    <= next_cmd_q;
            lane_n                   <= next_lane_n;
            mem_addr                 <= next_mem_addr;
            dq_out                   <= next_dq_out;
            dq_oe                    <= next_dq_oe;
            mem_ce_n                 <= next_ce_n;
            mem_we_n                 <= next_we_n;
            mem_oe_n                 <= next_oe_n;
            save_request_busy_pin_oe <= next_pin_oe;
            rsp_valid                <= next_rsp_valid;
            rsp_rdata                <= next_rsp_rdata;
            unsaved_writes           <= next_dirty;
        end
    end

endmodule : nv_host

/* tb/nv_host_checker.sv */
module nv_host_checker (
    input wire logic       clk_sys,
    input wire logic       rst,
    input wire logic       req_valid,
    input wire logic       req_ready,
    input wire logic [1:0] req_lane_n,
    input wire logic       rsp_valid,
    input wire logic       cmd_ready,
    input wire logic       save_valid,
    input wire logic       save_ready,
    input wire logic       busy,
    input wire logic       mem_ce_n,
    input wire logic       mem_we_n,
    input wire logic       mem_oe_n,
    input wire logic       lower_lane_enable_n,
    input wire logic       upper_lane_enable_n,
    input wire logic [1:0] dq_oe,
    input wire logic       save_request_busy_pin_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    property p_rsp; req_valid && req_ready && req_lane_n != 2'h3 |-> ##5 rsp_valid; endproperty
    a_rsp: assert property (p_rsp) else $error("access answer late");
    property p_nolane; req_valid && req_ready && req_lane_n == 2'h3 |=> rsp_valid && mem_ce_n;
    endproperty
    a_nolane: assert property (p_nolane) else $error("no-lane access strobed");
    property p_strobe; $fell(mem_ce_n) |-> !mem_ce_n [*4] ##1 mem_ce_n; endproperty
    a_strobe: assert property (p_strobe) else $error("strobe length wrong");
    property p_pin; !mem_ce_n |-> !save_request_busy_pin_oe; endproperty
    a_pin: assert property (p_pin) else $error("save pin low in a cycle");
    property p_wlane; !mem_ce_n && !mem_we_n |-> mem_oe_n && dq_oe == ~{upper_lane_enable_n,
        lower_lane_enable_n}; endproperty
    a_wlane: assert property (p_wlane) else $error("write lanes wrong");
    property p_rdrive; !mem_oe_n |-> mem_we_n && dq_oe == 2'h0; endproperty
    a_rdrive: assert property (p_rdrive) else $error("driving during read");
    property p_lock; busy |-> !req_ready && !cmd_ready && !save_ready; endproperty
    a_lock: assert property (p_lock) else $error("request taken while busy");
    property p_save; save_valid && save_ready |=> save_request_busy_pin_oe [*2] ##1
        !save_request_busy_pin_oe; endproperty
    a_save: assert property (p_save) else $error("save pulse wrong");
    c_save: cover property (save_valid && save_ready);
    c_write: cover property ($fell(mem_ce_n) && !mem_we_n);
    c_nolane: cover property (req_valid && req_ready && req_lane_n == 2'h3);
endmodule : nv_host_checker
bind nv_host nv_host_checker u_chk (
    .clk_sys(clk_sys), .rst(rst), .req_valid(req_valid), .req_ready(req_ready),
    .req_lane_n(req_lane_n), .rsp_valid(rsp_valid), .cmd_ready(cmd_ready),
    .save_valid(save_valid), .save_ready(save_ready), .busy(busy), .mem_ce_n(mem_ce_n),
    .mem_we_n(mem_we_n), .mem_oe_n(mem_oe_n), .lower_lane_enable_n(lower_lane_enable_n),
    .upper_lane_enable_n(upper_lane_enable_n), .dq_oe(dq_oe),
    .save_request_busy_pin_oe(save_request_busy_pin_oe));

/* tb/nv_mem_model.sv */
module nv_mem_model #(
    parameter logic [431:0] CMD_TABLE = '0
) (
    input  wire logic        clk_sys,
    input  wire logic        power_good,
    input  wire logic [17:0] mem_addr,
    input  wire logic        mem_ce_n,
    input  wire logic        mem_we_n,
    input  wire logic        mem_oe_n,
    input  wire logic        lower_lane_enable_n,
    input  wire logic        upper_lane_enable_n,
    input  wire logic [15:0] dq_out,
    input  wire logic        host_pull_low,
    output      logic [15:0] dq_in,
    output      logic        dev_pull_low
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0]  mem [256];
    logic [15:0]  last = 16'h0;
    logic [15:0]  lmask;
    logic [107:0] seq = '0;
    logic [107:0] next_seq;
    logic         ce_q = 1'b1, pg_q = 1'b0, dirty = 1'b0;
    int           lock = 0, saving = 0, ignored = 0, last_cmd = -1;
    assign lmask = {{8{!upper_lane_enable_n}}, {8{!lower_lane_enable_n}}};
    assign next_seq = {mem_addr, seq[107:18]};
    // Read decode.
    // A floating lane shows the inverse of its last value, so stale data cannot pass.
    assign dq_in = (!mem_ce_n && mem_we_n && !mem_oe_n && lock == 0)
                 ? (mem[mem_addr[7:0]] & lmask) | (~last & ~lmask) : ~last;
    assign dev_pull_low = saving > 0;
    always @(posedge clk_sys) begin
        ce_q <= mem_ce_n;
        pg_q <= power_good;
        last <= dq_in;
        lock <= (lock > 0) ? lock - 1 : 0;
        saving <= (saving > 0) ? saving - 1 : 0;
        if (power_good && !pg_q)
            lock <= 40;
        if (dirty && saving == 0 && ((!power_good && pg_q) || host_pull_low)) begin
            saving <= power_good ? 30 : 20;
            dirty <= 1'b0;
        end
        // Lockout; writes still land for three cycles after a save starts.
        if (!mem_ce_n && (lock > 0 || (saving > 0 && saving < 28) || !power_good
                          || host_pull_low)) begin
            if (ce_q)
                ignored <= ignored + 1;
        end else if (!mem_ce_n && !mem_we_n) begin
            if (!lower_lane_enable_n)
                mem[mem_addr[7:0]][7:0] <= dq_out[7:0];
            if (!upper_lane_enable_n)
                mem[mem_addr[7:0]][15:8] <= dq_out[15:8];
            // With both lanes off a write stores nothing.
            if (!lower_lane_enable_n || !upper_lane_enable_n)
                dirty <= 1'b1;
            seq <= '0;
        end else if (!mem_ce_n && ce_q) begin
            seq <= next_seq;
            for (int c = 0; c < 4; c++) begin
                if (next_seq == CMD_TABLE[c*108 +: 108]) begin
                    last_cmd <= c;
                    lock <= (c == 0) ? 30 : (c == 1) ? 15 : 5;
                    seq <= '0;
                    if (c < 2)
                        dirty <= 1'b0;
                end
            end
        end
    end
endmodule : nv_mem_model

/* tb/nv_host_tb_top.sv */
module nv_host_tb_top
    import nv_host_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int RC = 50;
    logic        clk_sys = 1'b0, rst = 1'b1, power_good = 1'b1;
    logic        req_valid = 1'b0, req_write = 1'b0, cmd_valid = 1'b0, save_valid = 1'b0;
    logic [15:0] req_wdata = '0, rsp_rdata, dq_in, dq_out;
    logic [17:0] req_addr = 18'h00042, mem_addr;
    logic [1:0]  req_lane_n = 2'h3, dq_oe;
    nv_cmd_t     cmd_code = CMD_STORE;
    logic        req_ready, rsp_valid, cmd_ready, save_ready, busy, unsaved_writes;
    logic        ce_n, we_n, oe_n, lo_n, up_n, pin_oe, dev_low;
    int          n_errors = 0, total_checks = 0, cyc = 0;
    wire logic   pin = !(pin_oe || dev_low);
    // Distinct addresses per command, so a sequence can only match its own command.
    function automatic logic [431:0] mk_table();
        logic [431:0] t;
        for (int i = 0; i < 24; i++)
            t[i*18 +: 18] = 18'h20e38 + 18'(i * 37);
        return t;
    endfunction : mk_table
    localparam logic [431:0] TABLE = mk_table();
    always #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_errors++;
            results();
        end
    end
    nv_host #(.RESTORE_CYC(RC), .STORE_CYC(40), .RECALL_CYC(20), .SOFT_SEQ_CYC(10),
        .CMD_TABLE(TABLE)) DUT (.clk_sys(clk_sys), .rst(rst), .power_good(power_good),
        .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
        .req_addr(req_addr), .req_wdata(req_wdata), .req_lane_n(req_lane_n),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_code(cmd_code), .save_valid(save_valid),
        .save_ready(save_ready), .busy(busy), .unsaved_writes(unsaved_writes),
        .mem_addr(mem_addr), .mem_ce_n(ce_n), .mem_we_n(we_n), .mem_oe_n(oe_n),
        .lower_lane_enable_n(lo_n), .upper_lane_enable_n(up_n), .dq_in(dq_in),
        .dq_out(dq_out), .dq_oe(dq_oe), .save_request_busy_pin_in(pin),
        .save_request_busy_pin_out(), .save_request_busy_pin_oe(pin_oe));
    nv_mem_model #(.CMD_TABLE(TABLE)) u_dev (.clk_sys(clk_sys), .power_good(power_good),
        .mem_addr(mem_addr), .mem_ce_n(ce_n), .mem_we_n(we_n), .mem_oe_n(oe_n),
        .lower_lane_enable_n(lo_n), .upper_lane_enable_n(up_n), .dq_out(dq_out),
        .host_pull_low(pin_oe), .dq_in(dq_in), .dev_pull_low(dev_low));
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
            n_errors++;
        if (got !== exp)
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    endtask : cmp
    function automatic logic pick(input int s);
        return s == 0 ? req_ready : s == 1 ? cmd_ready : s == 2 ? save_ready
             : s == 3 ? rsp_valid : !busy;
    endfunction : pick
    task automatic wt(input int s, output int n);
        n = 0;
        do begin
            @(negedge clk_sys);
            n++;
        end while (pick(s) !== 1'b1 && n < 400);
        cmp(32'(n < 400), 1);
    endtask : wt
    task automatic go(input int s, output int n);
        @(posedge clk_sys);
        {save_valid, cmd_valid, req_valid} <= 3'(1 << s);
        wt(s, n);
        @(posedge clk_sys);
        {save_valid, cmd_valid, req_valid} <= 3'h0;
    endtask : go
    task automatic acc(input logic w, input logic [15:0] d, input logic [1:0] ln,
                       output logic [15:0] q);
        int n;
        @(posedge clk_sys);
        req_write <= w;
        req_wdata <= d;
        req_lane_n <= ln;
        go(0, n);
        wt(3, n);
        q = rsp_rdata;
    endtask : acc
    task automatic t_restore();
        int n;
        wt(0, n);
        cmp(32'(n >= RC && n <= RC + 2), 1);
    endtask : t_restore
    task automatic t_lanes();
        logic [15:0] q;
        logic [15:0] exp [4] = '{16'h12c3, 16'h1200, 16'h00c3, 16'h0000};
        acc(1'b1, 16'h5aa5, 2'h0, q);
        acc(1'b1, 16'h1234, 2'h1, q);
        acc(1'b1, 16'hc3c3, 2'h2, q);
        cmp(unsaved_writes, 1);
        for (int l = 0; l < 4; l++) begin
            acc(1'b0, 16'h0000, 2'(l), q);
            cmp(q, exp[l]);
        end
    endtask : t_lanes
    task automatic t_save();
        int n;
        logic [15:0] q;
        acc(1'b1, 16'h0f0f, 2'h0, q);
        go(2, n);
        wt(4, n);
        cmp(32'(n > 75), 1);
        cmp(unsaved_writes, 0);
        go(2, n);
        wt(4, n);
        cmp(32'(n < 70), 1);
    endtask : t_save
    task automatic t_cmds();
        int n;
        logic [15:0] q;
        for (int c = 0; c < 4; c++) begin
            acc(1'b1, 16'(c), 2'h0, q);
            @(posedge clk_sys);
            cmd_code <= nv_cmd_t'(c);
            go(1, n);
            wt(4, n);
            cmp(u_dev.last_cmd, c);
            cmp(unsaved_writes, 32'(c > 1));
            cmp(u_dev.ignored, 0);
        end
    endtask : t_cmds
    task automatic t_power();
        logic [15:0] q;
        acc(1'b1, 16'h7777, 2'h0, q);
        @(posedge clk_sys);
        power_good <= 1'b0;
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
        cmp(req_ready, 0);
        cmp(u_dev.dirty, 0);
        @(posedge clk_sys);
        power_good <= 1'b1;
        t_restore();
    endtask : t_power
    task automatic results();
        if (n_errors == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : results
    initial begin
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        t_restore();
        t_lanes();
        t_save();
        t_cmds();
        t_power();
        results();
    end
endmodule : nv_host_tb_top
